// *** shared/acs_pkg.sv ***
// Constants and helpers for the amplifier compensation select block.
// Assumes a 16-bit register word and a single system clock.
package acs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          ADDR_W           = 5;
    localparam int          DATA_W           = 16;
    localparam logic [4:0]  AMP_COMP_TWO_OFS = 5'h05;
    localparam logic [15:0] AMP_COMP_TWO_RST = 16'h0110;

    // ------------------------------------------------------------
    // Field positions of the compensation word
    // ------------------------------------------------------------
    localparam int MANUAL_BIT = 15;
    localparam int RZ_LSB     = 12;
    localparam int RP_LSB     = 9;
    localparam int CCHI_LSB   = 6;
    localparam int CF_LSB     = 3;
    localparam int CC0_BIT    = 2;
    localparam int GM_LSB     = 0;

    // ------------------------------------------------------------
    // Fixed settings forced while in safe mode
    // ------------------------------------------------------------
    localparam logic [1:0] SAFE_GM   = 2'h2;
    localparam logic [2:0] SAFE_RP   = 3'h0;
    localparam logic [2:0] SAFE_RZ   = 3'h0;
    localparam logic [2:0] SAFE_CCHI = 3'h7;
    localparam logic [2:0] SAFE_CF   = 3'h5;
    localparam logic       SAFE_CC0  = 1'h1;

    typedef enum logic [1:0] {
        ACS_MODE_MANUAL,
        ACS_MODE_SAFE,
        ACS_MODE_AUTO
    } acs_mode_t;

    // Packs amplifier settings into the register word layout
    function automatic logic [15:0] acs_pack(
        input logic       manual,
        input logic [2:0] rz,
        input logic [2:0] rp,
        input logic [2:0] ccHi,
        input logic [2:0] cf,
        input logic       cc0,
        input logic [1:0] gm
    );
        acs_pack = {manual, rz, rp, ccHi, cf, cc0, gm};
    endfunction : acs_pack

endpackage : acs_pkg

// *** src/acs_amp_comp_select.sv ***
// Second compensation register and the selection of amplifier compensation.
// Assumes the serial port decoder delivers word-wide register strobes on clk_sys,
// and that the first compensation register supplies its safe-mode bit on clk_sys.
module acs_amp_comp_select
    import acs_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Register port from the serial interface decoder
    input  wire logic              regWrEn,
    input  wire logic              regRdEn,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    output      logic [DATA_W-1:0] regRdData_q,
    output      logic              regRdValid_q,
    // Mode bit from the first compensation register
    input  wire logic              safeCompMode,
    // Settings from the autocompensation logic
    input  wire logic [1:0]        autoGm,
    input  wire logic [2:0]        autoRp,
    input  wire logic [2:0]        autoRz,
    input  wire logic [2:0]        autoCcHi,
    input  wire logic [2:0]        autoCf,
    input  wire logic              autoCc0,
    // Settings to the force amplifier compensation network, then the manual and safe mode flags
    output      logic [1:0]        ampGm_q,
    output      logic [2:0]        ampRp_q,
    output      logic [2:0]        ampRz_q,
    output      logic [2:0]        ampCcHi_q,
    output      logic [2:0]        ampCf_q,
    output      logic              ampCc0_q,
    output      logic              manualActive_q,
    output      logic              safeActive_q
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [DATA_W-1:0] compTwo_q;
    logic [DATA_W-1:0] compTwo_d;
    logic              safeHold_q;
    logic              safeHold_d;
    logic              hitAddr;

    assign hitAddr = (regAddr == AMP_COMP_TWO_OFS);

    always_comb begin
        compTwo_d  = compTwo_q;
        safeHold_d = 1'h0;
        if (regWrEn && hitAddr) begin
            compTwo_d = regWrData;
        end
    end

    // Safe hold keeps the amplifier in safe mode for the first cycle after reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            compTwo_q  <= AMP_COMP_TWO_RST;
            safeHold_q <= 1'h1;
        end else begin
            compTwo_q  <= compTwo_d;
            safeHold_q <= safeHold_d;
        end
    end

    // ------------------------------------------------------------
    // Compensation selection
    // ------------------------------------------------------------
    acs_mode_t         mode;
    logic [DATA_W-1:0] appliedWord;

    acs_comp_mux u_mux (
        .storedWord   (compTwo_q),
        .safeCompMode (safeCompMode),
        .safeHold     (safeHold_q),
        .autoGm       (autoGm),
        .autoRp       (autoRp),
        .autoRz       (autoRz),
        .autoCcHi     (autoCcHi),
        .autoCf       (autoCf),
        .autoCc0      (autoCc0),
        .mode         (mode),
        .appliedWord  (appliedWord)
    );

    // ------------------------------------------------------------
    // Amplifier outputs
    // ------------------------------------------------------------
    logic [1:0] ampGm_d;
    logic [2:0] ampRp_d;
    logic [2:0] ampRz_d;
    logic [2:0] ampCcHi_d;
    logic [2:0] ampCf_d;
    logic       ampCc0_d;
    logic       manualActive_d;
    logic       safeActive_d;

    always_comb begin
        ampGm_d        = appliedWord[GM_LSB +: 2];
        ampRp_d        = appliedWord[RP_LSB +: 3];
        ampRz_d        = appliedWord[RZ_LSB +: 3];
        ampCcHi_d      = appliedWord[CCHI_LSB +: 3];
        ampCf_d        = appliedWord[CF_LSB +: 3];
        ampCc0_d       = appliedWord[CC0_BIT];
        manualActive_d = (mode == ACS_MODE_MANUAL);
        safeActive_d   = (mode == ACS_MODE_SAFE);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ampGm_q        <= SAFE_GM;
            ampRp_q        <= SAFE_RP;
            ampRz_q        <= SAFE_RZ;
            ampCcHi_q      <= SAFE_CCHI;
            ampCf_q        <= SAFE_CF;
            ampCc0_q       <= SAFE_CC0;
            manualActive_q <= 1'h0;
            safeActive_q   <= 1'h1;
        end else begin
            ampGm_q        <= ampGm_d;
            ampRp_q        <= ampRp_d;
            ampRz_q        <= ampRz_d;
            ampCcHi_q      <= ampCcHi_d;
            ampCf_q        <= ampCf_d;
            ampCc0_q       <= ampCc0_d;
            manualActive_q <= manualActive_d;
            safeActive_q   <= safeActive_d;
        end
    end

    // ------------------------------------------------------------
    // Readback
    // ------------------------------------------------------------
    logic [DATA_W-1:0] readWord;
    logic [DATA_W-1:0] regRdData_d;
    logic              regRdValid_d;

    always_comb begin
        unique case (mode)
            ACS_MODE_MANUAL: readWord = compTwo_q;
            ACS_MODE_AUTO:   readWord = appliedWord;
            ACS_MODE_SAFE:   readWord = compTwo_q;
            default:         readWord = compTwo_q;
        endcase
    end

    always_comb begin
        regRdValid_d = regRdEn;
        regRdData_d  = regRdData_q;
        if (regRdEn) begin
            regRdData_d = hitAddr ? readWord : '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            regRdData_q  <= '0;
            regRdValid_q <= 1'h0;
        end else begin
            regRdData_q  <= regRdData_d;
            regRdValid_q <= regRdValid_d;
        end
    end

endmodule : acs_amp_comp_select

// *** src/acs_comp_mux.sv ***
// Priority select of the compensation settings applied to the amplifier.
// Assumes all inputs come from logic on the same clock; purely combinational.
module acs_comp_mux
    import acs_pkg::*;
(
    input  wire logic [15:0] storedWord,
    input  wire logic        safeCompMode,
    input  wire logic        safeHold,
    input  wire logic [1:0]  autoGm,
    input  wire logic [2:0]  autoRp,
    input  wire logic [2:0]  autoRz,
    input  wire logic [2:0]  autoCcHi,
    input  wire logic [2:0]  autoCf,
    input  wire logic        autoCc0,
    output      acs_mode_t   mode,
    output      logic [15:0] appliedWord
);

    // ------------------------------------------------------------
    // Mode priority: manual, then safe, then automatic
    // ------------------------------------------------------------
    always_comb begin
        if (storedWord[MANUAL_BIT]) begin
            mode = ACS_MODE_MANUAL;
        end else if (!safeCompMode || safeHold) begin
            mode = ACS_MODE_SAFE;
        end else begin
            mode = ACS_MODE_AUTO;
        end
    end

    always_comb begin
        unique case (mode)
            ACS_MODE_MANUAL: appliedWord = storedWord;
            ACS_MODE_SAFE:   appliedWord = acs_pack(1'h0, SAFE_RZ, SAFE_RP,
                                 SAFE_CCHI, SAFE_CF, SAFE_CC0, SAFE_GM);
            ACS_MODE_AUTO:   appliedWord = acs_pack(1'h0, autoRz, autoRp,
                                 autoCcHi, autoCf, autoCc0, autoGm);
            default:         appliedWord = acs_pack(1'h0, SAFE_RZ, SAFE_RP,
                                 SAFE_CCHI, SAFE_CF, SAFE_CC0, SAFE_GM);
        endcase
    end

endmodule : acs_comp_mux

// *** verif/acs_amp_comp_select_assertions.sv ***
// Port assertions for the compensation select block.
// Assumes binding to the block's top module; one clock domain.
module acs_amp_comp_select_chk (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [4:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regRdValid_q,
    input wire logic        safeCompMode,
    input wire logic [2:0]  autoRz,
    input wire logic [1:0]  ampGm_q,
    input wire logic [2:0]  ampRz_q,
    input wire logic [2:0]  ampCcHi_q,
    input wire logic [2:0]  ampCf_q,
    input wire logic        ampCc0_q,
    input wire logic        manualActive_q,
    input wire logic        safeActive_q
);
    timeunit 1ns / 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_man_wr; regWrEn && regAddr == 5'h05 && regWrData[15] ##1 !regWrEn; endsequence
    sequence s_auto; !$past(rst) && safeCompMode ##1 !manualActive_q; endsequence
    chk_read_valid: assert property (regRdEn |=> regRdValid_q) else $error("no valid");
    chk_valid_cause: assert property (regRdValid_q |-> $past(regRdEn))
        else $error("extra valid");
    chk_manual_rz: assert property (s_man_wr |=> manualActive_q
        && ampRz_q == $past(regWrData[14:12], 2)) else $error("manual word not applied");
    chk_safe_values: assert property (safeActive_q |-> ampGm_q == 2'h2 && ampRz_q == 3'h0
        && ampCcHi_q == 3'h7 && ampCf_q == 3'h5 && ampCc0_q) else $error("bad safe setting");
    chk_safe_select: assert property (!safeCompMode |=> safeActive_q || manualActive_q)
        else $error("safe mode not applied");
    chk_manual_first: assert property (manualActive_q |-> !safeActive_q)
        else $error("mode clash");
    chk_auto_follow: assert property (s_auto |-> !safeActive_q && ampRz_q == $past(autoRz))
        else $error("auto setting not applied");
    chk_reset_safe: assert property ($past(rst) |-> safeActive_q && !manualActive_q)
        else $error("not safe after reset");
endmodule : acs_amp_comp_select_chk
bind acs_amp_comp_select acs_amp_comp_select_chk i_chk (.*);

// *** verif/acs_amp_comp_select_test.sv ***
// Self-checking bench for the compensation select block.
// Assumes the host model owns the register port; the bench drives the rest.
module acs_amp_comp_select_test
    import acs_pkg::*;
;
    timeunit 1ns / 1ps;
    localparam logic [15:0] MAN_W  = 16'hB2AB;
    localparam logic [15:0] AUTO_W = 16'h5CD1;
    logic        clk_sys = 1'h0, rst = 1'h1, safeCompMode = 1'h0;
    logic        regWrEn, regRdEn, regRdValid_q, autoCc0, ampCc0_q, manualActive_q, safeActive_q;
    logic [1:0]  autoGm, ampGm_q;
    logic [2:0]  autoRp, autoRz, autoCcHi, autoCf, ampRp_q, ampRz_q, ampCcHi_q, ampCf_q;
    logic [4:0]  regAddr;
    logic [14:0] autoW = 15'h0000;
    logic [15:0] regWrData, regRdData_q;
    logic [16:0] rdQ, obs;
    int          fails = 0, totalChecks = 0;
    assign obs = {safeActive_q, manualActive_q, ampRz_q, ampRp_q, ampCcHi_q, ampCf_q,
                  ampCc0_q, ampGm_q};
    assign {autoRz, autoRp, autoCcHi, autoCf, autoCc0, autoGm} = autoW;
    acs_amp_comp_select i_dut (.*);
    acs_host_model i_host (.*);
    initial forever #2 clk_sys = ~clk_sys;
    initial begin
        repeat (3000) @(posedge clk_sys);
        fails++;
        endOfTest();
    end
    task automatic endOfTest();
        $display("checks %0d fails %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : endOfTest
    // Reads address a and compares applied settings and the read answer
    task automatic look(input logic [16:0] eo, input logic [4:0] a, input logic [16:0] er);
        i_host.acc(1'h0, a, 16'h0000, rdQ);
        totalChecks += 2;
        if (obs !== eo || rdQ !== er) begin
            fails++;
            $display("BAD %0t applied %h/%h read %h/%h", $time, obs, eo, rdQ, er);
        end
    endtask : look
    task automatic t_safe();
        i_host.acc(1'h1, 5'h04, MAN_W, rdQ);
        look({1'h1, 16'h01EE}, AMP_COMP_TWO_OFS, {1'h1, 16'h0110});
        look({1'h1, 16'h01EE}, 5'h04, 17'h10000);
        $display("test safe done");
    endtask : t_safe
    task automatic t_manual();
        i_host.acc(1'h1, AMP_COMP_TWO_OFS, MAN_W, rdQ);
        look({1'h0, MAN_W}, AMP_COMP_TWO_OFS, {1'h1, MAN_W});
        $display("test manual done");
    endtask : t_manual
    task automatic t_auto();
        i_host.acc(1'h1, AMP_COMP_TWO_OFS, 16'h0110, rdQ);
        safeCompMode <= 1'h1;
        autoW        <= AUTO_W[14:0];
        look({1'h0, AUTO_W}, AMP_COMP_TWO_OFS, {1'h1, AUTO_W});
        $display("test auto done");
    endtask : t_auto
    // Reset in mid-run: register back to default, safe for the hold cycle, then auto
    task automatic t_reset();
        i_host.acc(1'h1, AMP_COMP_TWO_OFS, MAN_W, rdQ);
        rst <= 1'h1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        repeat (2) @(posedge clk_sys);
        totalChecks++;
        if (obs !== {1'h1, 16'h01EE}) begin
            fails++;
            $display("BAD %0t not safe after reset %h", $time, obs);
        end
        look({1'h0, AUTO_W}, AMP_COMP_TWO_OFS, {1'h1, AUTO_W});
        $display("test reset done");
    endtask : t_reset
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        t_safe();
        t_manual();
        t_auto();
        t_reset();
        endOfTest();
    end
endmodule : acs_amp_comp_select_test

// *** verif/acs_host_model.sv ***
// Host controller model issuing register accesses on the strobe port.
// Assumes read data is answered one clock after the read strobe.
module acs_host_model (
    input  wire logic        clk_sys,
    input  wire logic        regRdValid_q,
    input  wire logic [15:0] regRdData_q,
    output      logic        regWrEn,
    output      logic        regRdEn,
    output      logic [4:0]  regAddr,
    output      logic [15:0] regWrData
);
    timeunit 1ns / 1ps;
    initial {regWrEn, regRdEn, regAddr, regWrData} = 23'h000000;
    // Released strobes go low and address and data show inverted values so stale data never passes
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
                       output logic [16:0] q);
        @(posedge clk_sys);
        {regWrEn, regRdEn, regAddr, regWrData} <= {w, !w, a, d};
        @(posedge clk_sys);
        {regWrEn, regRdEn, regAddr, regWrData} <= {2'h0, ~a, ~d};
        @(posedge clk_sys);
        q = {regRdValid_q, regRdData_q};
    endtask : acc
endmodule : acs_host_model
